//--- verilog/cpu_regs_pkg.sv
// Contract
// - 8-bit accumulator holds operands and results
// - 16-bit index pair forms indexed addresses
// - Reset loads stack pointer with 00ff
// - Stack reset op sets low byte ff
// - Push decrements, pull increments stack pointer
// - Stack offset modes use stack pointer base
// - Program counter steps per fetch unless loaded
// - Reset loads program counter from fffe/ffff
// - Flag bits 6 and 5 read one
// - Overflow flag tracks two's complement overflow
// - Half-carry from bit 3 on add
// - Decimal adjust uses half-carry and carry
// - Mask set blocks maskable interrupts
// - Stack registers, set mask, then fetch vector
// - Interrupt entry pushes exactly five bytes
// - Upper index byte not stacked automatically
// - Highest-priority pending request serviced first
// - Interrupt return restores registers and mask
// - Mask one after reset, cleared by clear op
// - Negative flag equals result bit 7
// - Zero flag set on 00 result
// - Carry on add carry, borrow, shifts
package cpu_regs_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_ACC    = 8'h00;
  localparam logic [7:0] OFS_INDEX  = 8'h04;
  localparam logic [7:0] OFS_SP     = 8'h08;
  localparam logic [7:0] OFS_PC     = 8'h0c;
  localparam logic [7:0] OFS_FLAGS  = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  // ----------------------------------------------------------------
  // Flag layout and reset values
  // ----------------------------------------------------------------
  localparam int         BIT_V        = 7;
  localparam int         BIT_H        = 4;
  localparam int         BIT_I        = 3;
  localparam int         BIT_N        = 2;
  localparam int         BIT_Z        = 1;
  localparam int         BIT_C        = 0;
  localparam logic [7:0] FIXED_ONES   = 8'h60;
  localparam logic [7:0] FLAGS_RESET  = 8'h68;
  localparam logic [15:0] SP_RESET    = 16'h00ff;
  localparam logic [7:0] SP_LOW_RESET = 8'hff;
  localparam logic [15:0] RESET_VECTOR = 16'hfffe;
  localparam logic [15:0] IRQ_VECTOR_TOP = 16'hfffa;
  localparam logic [2:0] STACK_LAST   = 3'h4;

  // Pull targets, in interrupt-return order
  localparam logic [2:0] PIDX_FLAGS = 3'h0;
  localparam logic [2:0] PIDX_ACC   = 3'h1;
  localparam logic [2:0] PIDX_IX_LO = 3'h2;
  localparam logic [2:0] PIDX_PC_HI = 3'h3;
  localparam logic [2:0] PIDX_PC_LO = 3'h4;
  localparam logic [2:0] PIDX_IX_HI = 3'h5;

  typedef enum logic [4:0] {
    OP_NOP, OP_FETCH, OP_JUMP, OP_LOAD, OP_ADD, OP_ADC, OP_SUB, OP_AND, OP_DAA,
    OP_ASL, OP_LSR, OP_PUSH_ACC, OP_PULL_ACC, OP_PUSH_INDEX_HIGH, OP_PULL_INDEX_HIGH,
    OP_STACK_LOW_BYTE_RESET, OP_MASK_CLEAR, OP_MASK_SET, OP_INTERRUPT_RETURN,
    OP_EA_INDEX, OP_EA_STACK
  } op_t;

  typedef enum logic [2:0] {
    S_VEC_HI   = 3'b000,
    S_VEC_LO   = 3'b001,
    S_VEC_DONE = 3'b011,
    S_IDLE     = 3'b010,
    S_PUSH     = 3'b110,
    S_PULL     = 3'b111,
    S_PULL_END = 3'b101
  } state_t;

endpackage

//--- verilog/cpu_regs.sv
// The register addresses and the AHB-Lite interface to the registers were chosen for this implementation.
module cpu_regs
  import cpu_regs_pkg::*;
#(
  parameter int IRQ_COUNT = 8
) (
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  // AHB-Lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic                      hresp,
  output logic [31:0]               hrdata,
  // Core operation port
  input  wire logic                 op_valid,
  input  wire op_t                  op_code,
  input  wire logic [7:0]           op_data,
  input  wire logic [15:0]          op_addr,
  output logic                      op_ready,
  // Interrupt requests, index 0 highest priority
  input  wire logic [IRQ_COUNT-1:0] irq_pending,
  output logic                      irq_ack,
  output logic [7:0]                irq_index,
  // Stack and vector memory port, read data one cycle after request
  output logic                      mem_rd,
  output logic                      mem_wr,
  output logic [15:0]               mem_addr,
  output logic [7:0]                mem_wdata,
  input  wire logic [7:0]           mem_rdata,
  // Register view
  output logic [7:0]                accumulator,
  output logic [15:0]               index_pair,
  output logic [15:0]               stack_pointer,
  output logic [15:0]               program_counter,
  output logic [7:0]                condition_flags,
  output logic [15:0]               operand_addr
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    state_t      state;
    logic [2:0]  cnt;
    logic [2:0]  last;
    logic        pend;
    logic [2:0]  pidx;
    logic [15:0] vaddr;
    logic [7:0]  vec_hi;
    logic [7:0]  acc;
    logic [15:0] ix;
    logic [15:0] sp;
    logic [15:0] pc;
    logic [7:0]  flags;
    logic [15:0] ea;
    logic        dp_wr;
    logic [7:0]  dp_ofs;
    logic [31:0] rdata;
    logic        ack;
    logic [7:0]  ack_idx;
  } regs_t;

  localparam regs_t REGS_RESET = '{
    state: S_VEC_HI, cnt: 3'h0, last: 3'h0, pend: 1'b0, pidx: 3'h0,
    vaddr: RESET_VECTOR, vec_hi: 8'h00, acc: 8'h00, ix: 16'h0000,
    sp: SP_RESET, pc: 16'h0000, flags: FLAGS_RESET, ea: 16'h0000,
    dp_wr: 1'b0, dp_ofs: 8'h00, rdata: 32'h0000_0000, ack: 1'b0, ack_idx: 8'h00
  };

  regs_t st;
  regs_t next_st;
  logic  take;
  logic  accept;
  logic  mask_cleared_ok;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Sum as {carry, overflow, half, result}; subtraction reuses it
  function automatic logic [10:0] add8(input logic [7:0] a, input logic [7:0] b, input logic cin);
    logic [8:0] sum;
    logic [4:0] low;
    sum = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    return {sum[8], (a[7] == b[7]) && (sum[7] != a[7]), low[4], sum[7:0]};
  endfunction

  // Lowest index wins
  function automatic logic [7:0] first_set(input logic [IRQ_COUNT-1:0] req);
    logic [7:0] idx;
    idx = 8'h00;
    for (int k = IRQ_COUNT - 1; k >= 0; k--) begin
      if (req[k]) begin
        idx = 8'(k);
      end
    end
    return idx;
  endfunction

  function automatic logic [31:0] reg_read(input regs_t s, input logic [7:0] ofs);
    logic [31:0] v;
    unique case (ofs)
      OFS_ACC:    v = {24'h000000, s.acc};
      OFS_INDEX:  v = {16'h0000, s.ix};
      OFS_SP:     v = {16'h0000, s.sp};
      OFS_PC:     v = {16'h0000, s.pc};
      OFS_FLAGS:  v = {24'h000000, s.flags};
      OFS_STATUS: v = {28'h0000000, s.state != S_IDLE, s.state};
      default:    v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  // Zero-wait slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = st.rdata;
  assign irq_ack   = st.ack;
  assign irq_index = st.ack_idx;
  assign accumulator     = st.acc;
  assign index_pair      = st.ix;
  assign stack_pointer   = st.sp;
  assign program_counter = st.pc;
  assign condition_flags = st.flags;
  assign operand_addr    = st.ea;

  // Interrupt wins over a waiting operation; only taken when idle
  assign take     = (st.state == S_IDLE) && !st.flags[BIT_I] && (|irq_pending);
  assign op_ready = (st.state == S_IDLE) && !take;
  assign accept   = op_valid && op_ready;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic [10:0] alu;
    logic [7:0]  corr;
    logic        dcarry;
    alu       = 11'h000;
    corr      = 8'h00;
    dcarry    = 1'b0;
    next_st   = st;
    next_st.ack = 1'b0;
    next_st.pend = 1'b0;
    mem_rd    = 1'b0;
    mem_wr    = 1'b0;
    mem_addr  = st.sp;
    mem_wdata = 8'h00;
    mask_cleared_ok = 1'b0;

    // Bus address phase; read data captured for the data phase
    next_st.dp_wr = 1'b0;
    if (hsel && hready && htrans[1]) begin
      next_st.dp_wr  = hwrite;
      next_st.dp_ofs = haddr[7:0];
      next_st.rdata  = reg_read(st, haddr[7:0]);
    end

    // Byte pulled last cycle lands in its target
    if (st.pend) begin
      unique case (st.pidx)
        PIDX_FLAGS: begin
          next_st.flags = mem_rdata;
          mask_cleared_ok = 1'b1;
        end
        PIDX_ACC:   next_st.acc = mem_rdata;
        PIDX_IX_LO: next_st.ix[7:0] = mem_rdata;
        PIDX_PC_HI: next_st.pc[15:8] = mem_rdata;
        PIDX_PC_LO: next_st.pc[7:0] = mem_rdata;
        default:    next_st.ix[15:8] = mem_rdata;
      endcase
    end

    unique case (st.state)
      // Vector fetch, high byte first
      S_VEC_HI: begin
        mem_rd   = 1'b1;
        mem_addr = st.vaddr;
        next_st.state = S_VEC_LO;
      end
      S_VEC_LO: begin
        mem_rd   = 1'b1;
        mem_addr = st.vaddr + 16'h0001;
        next_st.vec_hi = mem_rdata;
        next_st.state  = S_VEC_DONE;
      end
      S_VEC_DONE: begin
        next_st.pc    = {st.vec_hi, mem_rdata};
        next_st.state = S_IDLE;
      end
      // Interrupt entry: PC low, PC high, X low, A, flags; H is left alone
      S_PUSH: begin
        mem_wr   = 1'b1;
        mem_addr = st.sp;
        unique case (st.cnt)
          3'h0:    mem_wdata = st.pc[7:0];
          3'h1:    mem_wdata = st.pc[15:8];
          3'h2:    mem_wdata = st.ix[7:0];
          3'h3:    mem_wdata = st.acc;
          default: mem_wdata = st.flags;
        endcase
        next_st.sp = st.sp - 16'h0001;
        if (st.cnt == STACK_LAST) begin
          next_st.flags[BIT_I] = 1'b1;
          next_st.state = S_VEC_HI;
        end else begin
          next_st.cnt = st.cnt + 3'h1;
        end
      end
      // Pre-increment then read; data captured next cycle
      S_PULL: begin
        mem_rd   = 1'b1;
        mem_addr = st.sp + 16'h0001;
        next_st.sp   = st.sp + 16'h0001;
        next_st.pend = 1'b1;
        next_st.pidx = st.cnt;
        if (st.cnt == st.last) begin
          next_st.state = S_PULL_END;
        end else begin
          next_st.cnt = st.cnt + 3'h1;
        end
      end
      S_PULL_END: begin
        next_st.state = S_IDLE;
      end
      S_IDLE: begin
        if (take) begin
          next_st.state   = S_PUSH;
          next_st.cnt     = 3'h0;
          next_st.ack     = 1'b1;
          next_st.ack_idx = first_set(irq_pending);
          next_st.vaddr   = IRQ_VECTOR_TOP - {7'h00, first_set(irq_pending), 1'b0};
        end else if (op_valid) begin
          unique case (op_code)
            OP_FETCH: next_st.pc = st.pc + 16'h0001;
            OP_JUMP:  next_st.pc = op_addr;
            OP_LOAD: begin
              next_st.acc = op_data;
              next_st.flags[BIT_V] = 1'b0;
              next_st.flags[BIT_N] = op_data[7];
              next_st.flags[BIT_Z] = (op_data == 8'h00);
            end
            OP_ADD, OP_ADC, OP_SUB: begin
              if (op_code == OP_SUB) begin
                alu = add8(st.acc, ~op_data, 1'b1);
                next_st.flags[BIT_C] = ~alu[10];
              end else begin
                alu = add8(st.acc, op_data, (op_code == OP_ADC) && st.flags[BIT_C]);
                next_st.flags[BIT_C] = alu[10];
                next_st.flags[BIT_H] = alu[8];
              end
              next_st.acc = alu[7:0];
              next_st.flags[BIT_V] = alu[9];
              next_st.flags[BIT_N] = alu[7];
              next_st.flags[BIT_Z] = (alu[7:0] == 8'h00);
            end
            OP_AND: begin
              next_st.acc = st.acc & op_data;
              next_st.flags[BIT_V] = 1'b0;
              next_st.flags[BIT_N] = st.acc[7] & op_data[7];
              next_st.flags[BIT_Z] = ((st.acc & op_data) == 8'h00);
            end
            OP_DAA: begin
              // Correction from H, C and the digits themselves
              dcarry = st.flags[BIT_C] || (st.acc > 8'h99);
              corr   = {1'b0, dcarry, dcarry, 2'b00,
                        st.flags[BIT_H] || (st.acc[3:0] > 4'h9),
                        st.flags[BIT_H] || (st.acc[3:0] > 4'h9), 1'b0};
              alu = add8(st.acc, corr, 1'b0);
              next_st.acc = alu[7:0];
              next_st.flags[BIT_C] = dcarry;
              next_st.flags[BIT_N] = alu[7];
              next_st.flags[BIT_Z] = (alu[7:0] == 8'h00);
            end
            OP_ASL: begin
              next_st.acc = {st.acc[6:0], 1'b0};
              next_st.flags[BIT_C] = st.acc[7];
              next_st.flags[BIT_V] = st.acc[7] ^ st.acc[6];
              next_st.flags[BIT_N] = st.acc[6];
              next_st.flags[BIT_Z] = (st.acc[6:0] == 7'h00);
            end
            OP_LSR: begin
              next_st.acc = {1'b0, st.acc[7:1]};
              next_st.flags[BIT_C] = st.acc[0];
              next_st.flags[BIT_V] = st.acc[0];
              next_st.flags[BIT_N] = 1'b0;
              next_st.flags[BIT_Z] = (st.acc[7:1] == 7'h00);
            end
            OP_PUSH_ACC, OP_PUSH_INDEX_HIGH: begin
              mem_wr    = 1'b1;
              mem_wdata = (op_code == OP_PUSH_ACC) ? st.acc : st.ix[15:8];
              next_st.sp = st.sp - 16'h0001;
            end
            OP_PULL_ACC, OP_PULL_INDEX_HIGH: begin
              next_st.state = S_PULL;
              next_st.cnt   = (op_code == OP_PULL_ACC) ? PIDX_ACC : PIDX_IX_HI;
              next_st.last  = (op_code == OP_PULL_ACC) ? PIDX_ACC : PIDX_IX_HI;
            end
            OP_INTERRUPT_RETURN: begin
              next_st.state = S_PULL;
              next_st.cnt   = PIDX_FLAGS;
              next_st.last  = PIDX_PC_LO;
            end
            OP_STACK_LOW_BYTE_RESET: next_st.sp[7:0] = SP_LOW_RESET;
            OP_MASK_CLEAR: begin
              next_st.flags[BIT_I] = 1'b0;
              mask_cleared_ok = 1'b1;
            end
            OP_MASK_SET: next_st.flags[BIT_I] = 1'b1;
            OP_EA_INDEX: next_st.ea = st.ix + op_addr;
            OP_EA_STACK: next_st.ea = st.sp + op_addr;
            default: next_st.ea = st.ea;
          endcase
        end
      end
      default: next_st.state = S_IDLE;
    endcase

    // Bus writes land last; software may set the mask but never clear it
    if (st.dp_wr) begin
      unique case (st.dp_ofs)
        OFS_ACC:   next_st.acc = hwdata[7:0];
        OFS_INDEX: next_st.ix = hwdata[15:0];
        OFS_SP:    next_st.sp = hwdata[15:0];
        OFS_PC:    next_st.pc = hwdata[15:0];
        OFS_FLAGS: next_st.flags = hwdata[7:0] | {4'h0, next_st.flags[BIT_I], 3'h0};
        default:   next_st.dp_ofs = st.dp_ofs;
      endcase
    end
    next_st.flags = next_st.flags | FIXED_ONES;
  end

  // Asynchronous reset sets stack, mask and vector fetch
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= REGS_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence stack_five;
    (st.state == S_PUSH && mem_wr)[*5];
  endsequence

  sequence vector_fetch;
    (st.state == S_VEC_HI && st.flags[BIT_I]) ##1 st.state == S_VEC_LO ##1 st.state == S_VEC_DONE;
  endsequence

  a_fixed_ones: assert property (st.flags[6:5] == 2'b11)
    else $error("flag bits 6 and 5 not one");
  a_stack_entry: assert property (take |=> stack_five ##1 vector_fetch)
    else $error("interrupt entry sequence wrong");
  a_mask_block: assert property (st.flags[BIT_I] && st.state == S_IDLE |=> !irq_ack)
    else $error("interrupt taken while masked");
  a_mask_clear_cause: assert property ($fell(st.flags[BIT_I]) |-> $past(mask_cleared_ok))
    else $error("mask cleared without clear op or return");
  a_stack_low_reset: assert property (accept && op_code == OP_STACK_LOW_BYTE_RESET && !st.dp_wr |=>
    st.sp == {$past(st.sp[15:8]), 8'hff})
    else $error("stack low reset wrong");
  a_push_step: assert property (accept && op_code == OP_PUSH_ACC && !st.dp_wr |=> st.sp == $past(st.sp) - 16'h0001)
    else $error("push did not decrement");
  a_fetch_step: assert property (accept && op_code == OP_FETCH && !st.dp_wr |=> st.pc == $past(st.pc) + 16'h0001)
    else $error("fetch did not advance");
  a_load_flags: assert property (accept && op_code == OP_LOAD && !st.dp_wr |=>
    st.flags[BIT_Z] == ($past(op_data) == 8'h00) && st.flags[BIT_N] == $past(op_data[7]))
    else $error("load flags wrong");
  a_vector_load: assert property (st.state == S_VEC_DONE && !st.dp_wr |=>
    st.pc == {$past(st.vec_hi), $past(mem_rdata)} && st.state == S_IDLE)
    else $error("vector not loaded");
  a_stack_base: assert property (accept && op_code == OP_EA_STACK |=> st.ea == $past(st.sp) + $past(op_addr))
    else $error("stack offset address wrong");
  a_irq_priority: assert property (take |=>
    ($past(irq_pending) & ~({IRQ_COUNT{1'b1}} << st.ack_idx)) == '0)
    else $error("lower priority request served first");

endmodule

//--- dv/tb_top.sv
module tb_top
  import cpu_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------
  // Signals
  // ------------------------------------------------
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic        op_valid, op_ready, irq_ack, mem_rd, mem_wr;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  op_t         op_code;
  logic [7:0]  op_data, irq_pending, irq_index, mem_wdata, mem_rdata, accumulator, condition_flags;
  logic [15:0] op_addr, mem_addr, index_pair, stack_pointer, program_counter, operand_addr;
  logic [7:0]  mem [0:65535];
  logic [15:0] wr_a [0:7];
  logic [7:0]  wr_d [0:7];
  logic [7:0]  a, b, ef;
  logic [15:0] rf;
  logic [7:0]  ca [0:2] = '{8'h80, 8'h0f, 8'h7f};
  logic [7:0]  cb [0:2] = '{8'h80, 8'h01, 8'h01};
  int          failures, check_count, wr_n, ack_n;

  assign hready = hreadyout; // Single slave drives bus ready

  cpu_regs DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .op_valid(op_valid), .op_code(op_code), .op_data(op_data), .op_addr(op_addr),
    .op_ready(op_ready), .irq_pending(irq_pending), .irq_ack(irq_ack), .irq_index(irq_index),
    .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .accumulator(accumulator), .index_pair(index_pair),
    .stack_pointer(stack_pointer), .program_counter(program_counter),
    .condition_flags(condition_flags), .operand_addr(operand_addr)
  );

  // ------------------------------------------------
  // Clock and memory model
  // ------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  // Read data one cycle late; idle line toggles so stale bytes never match
  always @(posedge hclk) begin
    mem_rdata <= mem_rd ? mem[mem_addr] : ~mem_rdata;
    if (mem_wr) begin
      mem[mem_addr] <= mem_wdata;
      if (wr_n < 8) begin
        wr_a[wr_n] <= mem_addr;
        wr_d[wr_n] <= mem_wdata;
      end
      wr_n <= wr_n + 1;
    end
    if (irq_ack) ack_n <= ack_n + 1;
  end

  // ------------------------------------------------
  // Tasks and expectations
  // ------------------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task give_verdict;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task ran_out;
    failures++;
    $display("mismatch at %0t: wait ran out", $time);
    give_verdict;
  endtask

  task wait_hready;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
      if (n > 20) ran_out;
    end while (hready !== 1'b1);
  endtask

  // One single word transfer; address phase held until ready
  task ahb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, ad};
    hwrite <= w;
    wait_hready;
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    wait_hready;
    rd = hrdata;
  endtask

  // Wait until the core port is idle again; bounded
  task settle;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
      if (n > 50) ran_out;
    end while (op_ready !== 1'b1);
  endtask

  task op(input op_t c, input logic [7:0] d);
    op_valid <= 1'b1;
    op_code <= c;
    op_data <= d;
    settle;
    op_valid <= 1'b0;
    settle;
  endtask

  // Sum and flag byte of an add with the mask held at one
  function automatic logic [15:0] add_exp(input logic [7:0] x, input logic [7:0] y);
    logic [8:0] s;
    logic [4:0] hs;
    logic       v;
    s = {1'b0, x} + {1'b0, y};
    hs = {1'b0, x[3:0]} + {1'b0, y[3:0]};
    v = (x[7] == y[7]) && (s[7] != x[7]);
    return {s[7:0], v, 2'b11, hs[4], 1'b1, s[7], s[7:0] == 8'h00, s[8]};
  endfunction

  // ------------------------------------------------
  // Main sequence
  // ------------------------------------------------
  initial begin
    void'($urandom(38));
    {hresetn, hsel, hwrite, op_valid, failures, check_count, wr_n, ack_n} = '0;
    {haddr, hwdata, htrans, op_data, op_addr, irq_pending, mem_rdata} = '0;
    hsize = 3'h2;
    op_code = OP_NOP;
    foreach (mem[i]) mem[i] = 8'($urandom);
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    settle;
    chk(program_counter, {mem[16'hfffe], mem[16'hffff]});
    chk(stack_pointer, SP_RESET);
    chk(hresp, 1'b0);
    chk(condition_flags, FLAGS_RESET);
    ahb(1'b0, OFS_SP, 32'h0);
    chk(rd, {16'h0, SP_RESET});
    ahb(1'b0, 8'h18, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b1, OFS_FLAGS, 32'h0);
    ahb(1'b0, OFS_FLAGS, 32'h0);
    chk(rd, {24'h0, FLAGS_RESET});
    $display("test reset done");
    // Corner sums first, then random ones; requests held off by the mask
    for (int i = 0; i < 12; i++) begin
      a = (i < 3) ? ca[i] : 8'($urandom);
      b = (i < 3) ? cb[i] : 8'($urandom);
      irq_pending <= 8'($urandom);
      ahb(1'b1, OFS_ACC, {24'h0, a});
      op(OP_ADD, b);
      rf = add_exp(a, b);
      chk(accumulator, rf[15:8]);
      chk(condition_flags, rf[7:0]);
    end
    chk(ack_n, 0);
    $display("test add flags done");
    ahb(1'b1, OFS_SP, 32'h1234);
    op(OP_STACK_LOW_BYTE_RESET, 8'h00);
    chk(stack_pointer, 16'h12ff);
    ahb(1'b1, OFS_ACC, 32'h3c);
    wr_n = 0;
    op(OP_PUSH_ACC, 8'h00);
    chk(wr_n, 1);
    chk(wr_a[0], 16'h12ff);
    chk(wr_d[0], 8'h3c);
    chk(stack_pointer, 16'h12fe);
    ahb(1'b1, OFS_ACC, 32'h0);
    op(OP_PULL_ACC, 8'h00);
    chk(accumulator, 8'h3c);
    chk(stack_pointer, 16'h12ff);
    $display("test stack done");
    // Two pending requests; index 3 outranks index 5
    ahb(1'b1, OFS_SP, 32'h01c0);
    ahb(1'b1, OFS_INDEX, 32'habcd);
    ahb(1'b1, OFS_ACC, 32'h5a);
    ef = rf[7:0] & 8'hf7;
    irq_pending <= 8'h28;
    wr_n = 0;
    ack_n = 0;
    op(OP_MASK_CLEAR, 8'h00);
    for (int n = 0; ack_n == 0; n++) begin
      @(posedge hclk);
      if (n > 40) ran_out;
    end
    irq_pending <= 8'h00;
    settle;
    chk(irq_index, 8'h03);
    chk(wr_n, 5);
    for (int k = 0; k < 5; k++) chk(wr_a[k], 16'h01c0 - 16'(k));
    chk(wr_d[2], 8'hcd);
    chk(wr_d[3], 8'h5a);
    chk(wr_d[4], ef);
    chk(condition_flags, ef | 8'h08);
    chk(program_counter, {mem[16'hfff4], mem[16'hfff5]});
    chk(stack_pointer, 16'h01bb);
    chk(index_pair, 16'habcd);
    $display("test interrupt entry done");
    ahb(1'b1, OFS_ACC, 32'h0);
    op(OP_INTERRUPT_RETURN, 8'h00);
    chk(condition_flags, ef);
    chk(accumulator, 8'h5a);
    chk(index_pair, 16'habcd);
    chk(program_counter, {wr_d[1], wr_d[0]});
    chk(stack_pointer, 16'h01c0);
    $display("test interrupt return done");
    // Decimal adjust after a low-digit overflow and a half carry
    op(OP_LOAD, 8'h15);
    op(OP_ADD, 8'h27);
    op(OP_DAA, 8'h00);
    chk(accumulator, 8'h42);
    op(OP_LOAD, 8'h09);
    op(OP_ADD, 8'h08);
    op(OP_DAA, 8'h00);
    chk(accumulator, 8'h17);
    // Address forming and program counter loading
    ahb(1'b1, OFS_INDEX, 32'h1000);
    op_addr <= 16'h0234;
    op(OP_EA_INDEX, 8'h00);
    chk(operand_addr, 16'h1234);
    op(OP_EA_STACK, 8'h00);
    chk(operand_addr, 16'h03f4);
    op_addr <= 16'h4321;
    op(OP_JUMP, 8'h00);
    chk(program_counter, 16'h4321);
    op(OP_FETCH, 8'h00);
    chk(program_counter, 16'h4322);
    $display("test adjust and address done");
    give_verdict;
  end
endmodule
